// File: bench/fws_flash_model.sv
// Purpose: Behavioural flash status model for the host bench
// Assumes: Read ends when ce_n/oe_n rise, write when we_n rises
// Notes: Released data bus shows the inverse of the last value
`timescale 1ns/1ps
module fws_flash_model (
  input wire logic aclk,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [15:0] dq_w,
  input wire logic go,
  input wire logic erase,
  input wire logic stuck,
  input wire logic [15:0] datum,
  input wire logic [3:0] reads,
  output logic [15:0] dq_r,
  output logic rb_oe
);
  logic busy_q = 1'b0;
  logic stuck_q = 1'b0;
  logic erase_q = 1'b0;
  logic tog_q = 1'b0;
  logic rd_q = 1'b0;
  logic wr_q = 1'b0;
  logic [3:0] left_q = 4'h1;
  logic [15:0] arr_q = 16'hffff;
  logic [15:0] last_q = 16'h0000;
  logic [15:0] stat;
  wire rd = !ce_n && !oe_n;
  wire wr = !ce_n && !we_n;
  always_comb begin
    stat = 16'h0000;
    stat[7] = erase_q ? 1'b0 : ~arr_q[7];
    stat[6] = tog_q;
    stat[5] = stuck_q;
    stat[2] = erase_q ? tog_q : 1'b0;
    dq_r = !rd ? ~last_q : (busy_q ? stat : arr_q);
  end
  assign rb_oe = busy_q;
  always_ff @(posedge aclk) begin
    rd_q <= rd;
    wr_q <= wr;
    if (rd)
      last_q <= dq_r;
    if (go) begin
      busy_q <= 1'b1;
      stuck_q <= stuck;
      erase_q <= erase;
      arr_q <= datum;
      left_q <= reads;
    end else if (rd_q && !rd) begin
      tog_q <= ~tog_q;
      if (busy_q && !stuck_q) begin
        left_q <= left_q - 4'h1;
        if (left_q == 4'h1)
          busy_q <= 1'b0;
      end
    end else if (wr_q && !wr && dq_w == 16'h00f0) begin
      busy_q <= 1'b0;
      stuck_q <= 1'b0;
    end
  end
endmodule // fws_flash_model

// File: bench/fws_host_bench.sv
// Purpose: Self-checking bench for the flash status host
// Assumes: ACC_CYC of 2, pull-up on the ready/busy line
// Notes: Random program and erase jobs in both status modes
`timescale 1ns/1ps
`include "fws_cfg.svh"
module fws_host_bench;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic ce_n, oe_n, we_n, dq_oe, rb_oe, go, erase, stuck;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, reads;
  logic [1:0] bresp, rresp;
  logic [21:0] faddr, exp_addr;
  logic [15:0] dq_o, dq_i, datum;
  int error_cnt = 0;
  int samples_checked = 0;
  wire rb_n = rb_oe ? 1'b0 : 1'b1;
  fws_host #(.ACC_CYC(2)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(faddr),
    .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_i), .ready_busy_n(rb_n));
  fws_flash_model fm (.aclk(aclk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_w(dq_o),
    .go(go), .erase(erase), .stuck(stuck), .datum(datum), .reads(reads),
    .dq_r(dq_i), .rb_oe(rb_oe));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bit five clear so a finished toggle pair never looks timed out
  function automatic logic [15:0] job_datum(input logic er, input logic [15:0] rnd);
    return (rnd & 16'hffdf) | (er ? 16'h0080 : 16'h0000);
  endfunction
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw_ok && w_ok));
    while (!bvalid) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_idle(output logic [31:0] d);
    logic [1:0] r;
    int n;
    n = 0;
    do begin
      axi_rd(`FWS_OFS_STAT, d, r);
      n++;
    end while (d[0] !== 1'b0 && n < 300);
    check("stat_busy", {31'h0, d[0]}, 32'h0);
  endtask
  task automatic fire(input logic er, input logic stk);
    @(posedge aclk);
    erase <= er;
    stuck <= stk;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
  endtask
  task automatic job(input logic md, input logic er, input logic stk);
    logic [31:0] d;
    logic [1:0] r;
    datum = job_datum(er, 16'($urandom));
    exp_addr = 22'($urandom);
    reads = 4'($urandom_range(6, 1));
    axi_wr(`FWS_OFS_ADDR, {10'h000, exp_addr}, r);
    axi_wr(`FWS_OFS_DATA, {16'h0000, datum}, r);
    fire(er, stk);
    axi_wr(`FWS_OFS_CTRL, {30'h0, md, 1'b1}, r);
    wait_idle(d);
    check("pass", {31'h0, d[1]}, {31'h0, !stk});
    check("fail", {31'h0, d[2]}, {31'h0, stk});
    check("tmo", {31'h0, d[3]}, {31'h0, stk});
    check("ready", {31'h0, d[4]}, 32'h1);
    if (!stk)
      check("data", {16'h0, d[31:16]}, {16'h0, datum});
    axi_rd(`FWS_OFS_CTRL, d, r);
    check("mode", d, {30'h0, md, 1'b0});
  endtask
  always @(posedge aclk) begin
    if (aresetn && !ce_n)
      check("flash_addr", {10'h0, faddr}, {10'h0, exp_addr});
  end
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    #500000;
    error_cnt++;
    complete_run();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, go, erase, stuck} = 9'h000;
    {awaddr, araddr, wdata, datum, exp_addr, reads} = '0;
    wstrb = 4'hf;
    d = $urandom(32'h288c);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`FWS_OFS_ADDR, d, r);
    check("addr_rst", d, 32'h0);
    axi_rd(`FWS_OFS_DATA, d, r);
    check("data_rst", d, 32'h000000ff);
    axi_rd(`FWS_OFS_STAT, d, r);
    check("stat_rst", {27'h0, d[4:0]}, 32'h10);
    axi_rd(8'h10, d, r);
    check("rd_unmapped", {r, d[29:0]}, 32'h80000000);
    axi_wr(8'h14, 32'h0, r);
    check("wr_unmapped", {30'h0, r}, 32'h2);
    for (int i = 0; i < 10; i++)
      job(i[0], 1'($urandom), 1'b0);
    job(1'b1, 1'b0, 1'b1);
    job(1'b1, 1'b1, 1'b1);
    axi_wr(`FWS_OFS_CTRL, 32'h8, r);
    wait_idle(d);
    check("raw_read", {16'h0, d[31:16]}, {16'h0, datum});
    fire(1'b0, 1'b1);
    axi_rd(`FWS_OFS_STAT, d, r);
    check("busy_line", {31'h0, d[4]}, 32'h0);
    axi_wr(`FWS_OFS_DATA, {16'h0000, `FWS_CMD_RESET}, r);
    axi_wr(`FWS_OFS_CTRL, 32'h4, r);
    wait_idle(d);
    axi_rd(`FWS_OFS_STAT, d, r);
    check("ready_line", {31'h0, d[4]}, 32'h1);
    complete_run();
  end
endmodule // fws_host_bench

// File: design/fws_bus_cycle.sv
// Purpose: One asynchronous flash read or write bus cycle
// Assumes: start only while not busy
// Notes: Strobes held ACC_CYC cycles, released with done
`timescale 1ns/1ps
`include "fws_cfg.svh"
module fws_bus_cycle #(
  parameter int ACC_CYC = `FWS_ACC_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire fws_pkg::fws_req_s req,
  output logic busy,
  output logic done,
  output logic [15:0] rdata,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [21:0] addr,
  output logic [15:0] dq_o,
  output logic dq_oe,
  input wire logic [15:0] dq_i
);
  logic [7:0] cnt_q;
  logic [7:0] len_q;

  // Strobe span count for the length check
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      len_q <= 8'h00;
    end else if (busy) begin
      len_q <= len_q + 8'h01;
    end else begin
      len_q <= 8'h00;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt_q <= 8'h00;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      addr <= 22'h000000;
      dq_o <= 16'h0000;
      dq_oe <= 1'b0;
      rdata <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (!busy && start) begin
        busy <= 1'b1;
        cnt_q <= 8'(ACC_CYC - 1);
        ce_n <= 1'b0;
        oe_n <= req.wr;
        we_n <= !req.wr;
        addr <= req.addr;
        dq_o <= req.data;
        dq_oe <= req.wr;
      end else if (busy) begin
        if (cnt_q == 8'h00) begin
          busy <= 1'b0;
          done <= 1'b1;
          ce_n <= 1'b1;
          oe_n <= 1'b1;
          we_n <= 1'b1;
          dq_oe <= 1'b0;
          rdata <= dq_i;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
      end
    end
  end

  chk_strobe_excl: assert property (@(posedge aclk) disable iff (!aresetn)
    !(!oe_n && !we_n)) else $error("read and write strobes both active");
  chk_cycle_len: assert property (@(posedge aclk) disable iff (!aresetn)
    done |-> len_q == 8'(ACC_CYC))
    else $error("bus cycle length wrong");
  chk_strobe_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    busy |-> (!ce_n && (oe_n != we_n)))
    else $error("strobes not held through the cycle");
endmodule // fws_bus_cycle

// File: design/fws_cfg.svh
// Purpose: Constants for the flash write-status polling controller
// Assumes: 100 MHz aclk, 16-bit flash data bus, word addressing
// Notes: Operation list below; tags mark the logic in the main file
// Operation
// - Host polls at the address being programmed
// - Host polls erase inside a selected sector
// - Host takes array data only from later reads; the host reports the final status read (last_q) in STAT bits 31:16 instead
// - Host compares two consecutive reads of toggle bit
// - Still toggling after timeout: fail and send reset
// - Host restarts status check from first step
// - Host rechecks polling bit after timeout bit high
`ifndef FWS_CFG_SVH
`define FWS_CFG_SVH

// Register offsets
`define FWS_OFS_CTRL 8'h00
`define FWS_OFS_ADDR 8'h04
`define FWS_OFS_DATA 8'h08
`define FWS_OFS_STAT 8'h0c

// Control fields
`define FWS_CTRL_START 0
`define FWS_CTRL_TOGGLE 1
`define FWS_CTRL_RAW_WR 2
`define FWS_CTRL_RAW_RD 3

// Status fields
`define FWS_STAT_BUSY 0
`define FWS_STAT_PASS 1
`define FWS_STAT_FAIL 2
`define FWS_STAT_TMO 3
`define FWS_STAT_RDY 4

// Flash status bit positions
`define FWS_DQ_POLL 7
`define FWS_DQ_TOG1 6
`define FWS_DQ_TMO 5

// Reset values and commands
`define FWS_ADDR_RST 22'h000000
`define FWS_DATA_RST 16'h00ff
`define FWS_CMD_RESET 16'h00f0

// Timing
`define FWS_CLK_NS 10
`define FWS_T_ACC_NS 70
`define FWS_ACC_CYC ((`FWS_T_ACC_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)

`endif

// File: design/fws_host.sv
// Purpose: AXI4-Lite controlled host that polls flash write status
// Assumes: Flash pins synchronous to aclk, one flash device
// Notes: Data polling or toggle check, reset command on failure
`timescale 1ns/1ps
`include "fws_cfg.svh"
module fws_host #(
  parameter int ACC_CYC = `FWS_ACC_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [21:0] flash_addr,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_i,
  input wire logic ready_busy_n
);
  fws_pkg::fws_state_e st_q;
  fws_pkg::fws_req_s req_q;
  logic start_q;
  logic cyc_busy;
  logic cyc_done;
  logic [15:0] cyc_rdata;
  logic [7:0] awaddr_q;
  logic aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_have_q;
  logic wr_fire;
  logic [21:0] addr_q;
  logic [15:0] data_q;
  logic toggle_mode_q;
  logic recheck_q;
  logic pass_q;
  logic fail_q;
  logic tmo_q;
  logic [15:0] first_q;
  logic [15:0] last_q;
  logic [2:0] reads_q;
  logic ok;
  logic go_poll;
  logic go_raw_wr;
  logic go_raw_rd;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Write channel capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == `FWS_OFS_CTRL || awaddr_q == `FWS_OFS_ADDR ||
                        awaddr_q == `FWS_OFS_DATA) ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign go_poll = wr_fire && awaddr_q == `FWS_OFS_CTRL && wstrb_q[0] &&
                   wdata_q[`FWS_CTRL_START];
  assign go_raw_wr = wr_fire && awaddr_q == `FWS_OFS_CTRL && wstrb_q[0] &&
                     wdata_q[`FWS_CTRL_RAW_WR];
  assign go_raw_rd = wr_fire && awaddr_q == `FWS_OFS_CTRL && wstrb_q[0] &&
                     wdata_q[`FWS_CTRL_RAW_RD];

  // Address and expected datum registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_q <= `FWS_ADDR_RST;
      data_q <= `FWS_DATA_RST;
    end else if (wr_fire && st_q == fws_pkg::S_IDLE) begin
      if (awaddr_q == `FWS_OFS_ADDR) begin
        addr_q <= 22'(merge({10'h000, addr_q}, wdata_q, wstrb_q));
      end
      if (awaddr_q == `FWS_OFS_DATA) begin
        data_q <= 16'(merge({16'h0000, data_q}, wdata_q, wstrb_q));
      end
    end
  end

  // Register reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `FWS_OFS_CTRL: s_axi_rdata <= {30'h00000000, toggle_mode_q, 1'b0};
          `FWS_OFS_ADDR: s_axi_rdata <= {10'h000, addr_q};
          `FWS_OFS_DATA: s_axi_rdata <= {16'h0000, data_q};
          `FWS_OFS_STAT: s_axi_rdata <= {last_q, 11'h000, ready_busy_n, tmo_q, fail_q,
                                         pass_q, st_q != fws_pkg::S_IDLE};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Status check outcome
  always_comb begin
    if (toggle_mode_q) begin
      ok = first_q[`FWS_DQ_TOG1] == last_q[`FWS_DQ_TOG1];
    end else begin
      ok = last_q[`FWS_DQ_POLL] == data_q[`FWS_DQ_POLL];
    end
  end

  // Polling sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= fws_pkg::S_IDLE;
      start_q <= 1'b0;
      req_q <= '0;
      toggle_mode_q <= 1'b0;
      recheck_q <= 1'b0;
      pass_q <= 1'b0;
      fail_q <= 1'b0;
      tmo_q <= 1'b0;
      first_q <= 16'h0000;
      last_q <= 16'h0000;
      reads_q <= 3'h0;
    end else begin
      start_q <= 1'b0;
      case (st_q)
        fws_pkg::S_IDLE: begin
          if (go_poll) begin
            toggle_mode_q <= wdata_q[`FWS_CTRL_TOGGLE];
            recheck_q <= 1'b0;
            pass_q <= 1'b0;
            fail_q <= 1'b0;
            tmo_q <= 1'b0;
            reads_q <= 3'h0;
            st_q <= fws_pkg::S_RD_A;
          end else if (go_raw_wr || go_raw_rd) begin
            req_q <= '{wr: go_raw_wr, addr: addr_q, data: data_q};
            start_q <= 1'b1;
            st_q <= fws_pkg::S_WAIT_RAW;
          end
        end
        fws_pkg::S_RD_A, fws_pkg::S_RD_B: begin
          req_q <= '{wr: 1'b0, addr: addr_q, data: 16'h0000};
          start_q <= 1'b1;
          st_q <= (st_q == fws_pkg::S_RD_A) ? fws_pkg::S_WAIT_A : fws_pkg::S_WAIT_B;
        end
        fws_pkg::S_WAIT_A: begin
          if (cyc_done) begin
            first_q <= cyc_rdata;
            last_q <= cyc_rdata;
            reads_q <= (reads_q == 3'h7) ? reads_q : reads_q + 3'h1;
            st_q <= toggle_mode_q ? fws_pkg::S_RD_B : fws_pkg::S_EVAL;
          end
        end
        fws_pkg::S_WAIT_B: begin
          if (cyc_done) begin
            last_q <= cyc_rdata;
            reads_q <= (reads_q == 3'h7) ? reads_q : reads_q + 3'h1;
            st_q <= fws_pkg::S_EVAL;
          end
        end
        fws_pkg::S_EVAL: begin
          if (ok) begin
            pass_q <= 1'b1;
            st_q <= fws_pkg::S_IDLE;
          end else if (recheck_q) begin
            st_q <= fws_pkg::S_RST;
          end else begin
            if (last_q[`FWS_DQ_TMO]) begin
              recheck_q <= 1'b1;
              tmo_q <= 1'b1;
            end
            st_q <= fws_pkg::S_RD_A;
          end
        end
        fws_pkg::S_RST: begin
          req_q <= '{wr: 1'b1, addr: addr_q, data: `FWS_CMD_RESET};
          start_q <= 1'b1;
          st_q <= fws_pkg::S_WAIT_RST;
        end
        fws_pkg::S_WAIT_RST: begin
          if (cyc_done) begin
            fail_q <= 1'b1;
            st_q <= fws_pkg::S_IDLE;
          end
        end
        fws_pkg::S_WAIT_RAW: begin
          if (cyc_done) begin
            last_q <= cyc_rdata;
            st_q <= fws_pkg::S_IDLE;
          end
        end
        default: st_q <= fws_pkg::S_IDLE;
      endcase
    end
  end

  fws_bus_cycle #(.ACC_CYC(ACC_CYC)) u_cycle (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start_q),
    .req(req_q),
    .busy(cyc_busy),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .ce_n(flash_ce_n),
    .oe_n(flash_oe_n),
    .we_n(flash_we_n),
    .addr(flash_addr),
    .dq_o(flash_dq_o),
    .dq_oe(flash_dq_oe),
    .dq_i(flash_dq_i)
  );

  sequence poll_issue;
    (st_q == fws_pkg::S_RD_A) ##1 start_q;
  endsequence

  chk_poll_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    poll_issue |-> (req_q.addr == addr_q && !req_q.wr))
    else $error("status read not at polled address");
  chk_erase_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    poll_issue |=> (!flash_ce_n && !flash_oe_n && flash_addr == addr_q))
    else $error("status read address not driven");
  chk_two_reads: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == fws_pkg::S_EVAL && toggle_mode_q) |-> reads_q >= 3'h2)
    else $error("toggle compared after fewer than two reads");
  chk_fail_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == fws_pkg::S_EVAL && !ok && recheck_q) |=> ##1 start_q ##1
      (!flash_we_n && flash_dq_oe && flash_dq_o == `FWS_CMD_RESET))
    else $error("reset command not issued after failure");
  // Eval, reset issue, start, ACC_CYC strobe cycles, done, flag
  localparam int FAIL_LAT = ACC_CYC + 4;

  chk_fail_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == fws_pkg::S_EVAL && !ok && recheck_q) |-> ##[FAIL_LAT:FAIL_LAT] fail_q)
    else $error("failure flag not raised");
  chk_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == fws_pkg::S_IDLE && go_poll) |=> (st_q == fws_pkg::S_RD_A && !recheck_q &&
      reads_q == 3'h0))
    else $error("status check did not restart from the top");
  chk_recheck_tmo: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == fws_pkg::S_EVAL && !ok && !recheck_q && last_q[`FWS_DQ_TMO]) |=>
      (recheck_q && tmo_q && st_q == fws_pkg::S_RD_A))
    else $error("no recheck after timeout bit");
  chk_pass_eval: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(pass_q) |-> $past(st_q) == fws_pkg::S_EVAL && $past(ok))
    else $error("pass set without a matching status read");
endmodule // fws_host

// File: design/fws_pkg.sv
// Purpose: Types for the flash write-status polling controller
// Assumes: 22-bit word address, 16-bit data
// Notes: Constants live in fws_cfg.svh
package fws_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_RD_A, S_WAIT_A, S_RD_B, S_WAIT_B, S_EVAL,
    S_RST, S_WAIT_RST, S_RAW, S_WAIT_RAW
  } fws_state_e;

  typedef struct packed {
    logic wr;
    logic [21:0] addr;
    logic [15:0] data;
  } fws_req_s;
endpackage
